/* File: shared/csd_pkg.sv */
// Shared constants and types for the two-channel cycle-steal transfer engine.
// Assumes a 20-bit byte address space and a 16-bit internal data bus.
package csd_pkg;
  localparam int CSD_CH_N = 2;
  localparam int CSD_AW = 20;
  localparam int CSD_DW = 16;
  localparam int CSD_CTL_W = 8;
  localparam int CSD_CW = 16;
  localparam int CSD_BUF_DEPTH = 2;
  localparam int CSD_PER_W = 20;

  // Control register field positions
  localparam int CSD_B_UNIT = 0;
  localparam int CSD_B_RPT = 1;
  localparam int CSD_B_REQ = 2;
  localparam int CSD_B_EN = 3;
  localparam int CSD_B_SFWD = 4;
  localparam int CSD_B_DFWD = 5;
  localparam logic [CSD_CTL_W-1:0] CSD_CTL_RST = 8'h00;

  // Own register window, never reachable as source or destination
  localparam logic [CSD_AW-1:0] CSD_HOLE_LO = 20'h00020;
  localparam logic [CSD_AW-1:0] CSD_HOLE_HI = 20'h0003f;

  // Request source select codes
  localparam logic [4:0] CSD_SEL_SW = 5'h00;
  localparam logic [4:0] CSD_SEL_EXT = 5'h01;
  localparam logic [4:0] CSD_SEL_PER0 = 5'h02;
  localparam logic [4:0] CSD_PER_N = 5'h14;

  // Pointer steps, counter step and idle pin level
  localparam logic [CSD_AW-1:0] CSD_STEP_B = 20'h00001;
  localparam logic [CSD_AW-1:0] CSD_STEP_W = 20'h00002;
  localparam logic [CSD_CW-1:0] CSD_CNT_ONE = 16'h0001;
  localparam logic [CSD_CW-1:0] CSD_CNT_ZERO = 16'h0000;
  localparam logic [1:0] CSD_PIN_IDLE = 2'h3;
  localparam logic [7:0] CSD_BYTE_ZERO = 8'h00;

  typedef enum logic [4:0] {
    CSD_S_IDLE = 5'h01,
    CSD_S_REQ = 5'h02,
    CSD_S_RD = 5'h04,
    CSD_S_PUSH = 5'h08,
    CSD_S_WR = 5'h10
  } csd_state_t;
endpackage : csd_pkg

/* File: logic/csd_buf2.sv */
// Small valid/ready buffer between source read and destination write.
// Assumes DEPTH is a power of two; same clock and enable as the engine.
`timescale 1ns/1ns
`default_nettype none
module csd_buf2
  import csd_pkg::*;
#(
  parameter int WIDTH = CSD_DW,
  parameter int DEPTH = CSD_BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] EMPTY = (PW+1)'(0);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } csd_buf_st_t;

  csd_buf_st_t q;
  csd_buf_st_t nxt;
  logic push;
  logic pop;

  // Honest flags from the occupancy count
  assign in_ready_o = (q.cnt != FULL);
  assign out_valid_o = (q.cnt != EMPTY);
  assign out_data_o = q.mem[q.rp];

  // Pointer and count update
  always_comb begin
    nxt = q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      nxt.mem[q.wp] = in_data_i;
      nxt.wp = q.wp + PW'(1);
    end
    if (pop) begin
      nxt.rp = q.rp + PW'(1);
    end
    if (push && !pop) begin
      nxt.cnt = q.cnt + (PW+1)'(1);
    end else if (pop && !push) begin
      nxt.cnt = q.cnt - (PW+1)'(1);
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= nxt;
    end
  end
endmodule : csd_buf2
`default_nettype wire

/* File: logic/csd_dma.sv */
// Two-channel cycle-stealing transfer engine on the shared on-chip bus.
// Assumes a bus arbiter answering bus_req_o with bus_gnt_i, a memory port
// that completes each access with acc_ready_i, and same-clock peripherals.
//
// What this block does
// (R01) Two channels; channel zero wins ties
// (R02) Moves between any address and fixed address
// (R03) Own register window never accessed
// (R04) Byte or word unit, 64K units max
// (R05) Channel pins trigger on falling or both edges
// (R06) Peripheral interrupts and software trigger request
// (R07) Source and destination never both forward
// (R08) Single mode: underflow clears enable
// (R09) Repeat mode: underflow reloads counter
// (R10) Interrupt pulse on counter underflow
// (R11) One unit per request, only when enabled
// (R12) Enable copies forward pointer and counter reload
// (R13) Fixed pointers writable only while disabled
// (R14) Registers readable; forward pointer reads live
// (R15) Transfers leave interrupt state untouched
// (R16) Control register six fields, upper bits zero
// (R17) Request flag sets always, clears before transfer
// (R18) Rewriting enable restarts the channel
// (R19) Read then write; odd word splits
// (R20) Bus held for one unit per request
// (R21) Pointer steps by unit, counter decrements
`timescale 1ns/1ns
`default_nettype none
module csd_dma
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [1:0] ctrl_we_i,
  input wire logic [CSD_CTL_W-1:0] ctrl_wdata_i,
  input wire logic [1:0] src_we_i,
  input wire logic [1:0] dst_we_i,
  input wire logic [CSD_AW-1:0] ptr_wdata_i,
  input wire logic [1:0] rld_we_i,
  input wire logic [CSD_CW-1:0] rld_wdata_i,
  input wire logic [1:0][4:0] req_sel_i,
  input wire logic [1:0] ext_both_edge_i,
  input wire logic [1:0] sw_req_i,
  input wire logic [CSD_PER_W-1:0] periph_irq_i,
  input wire logic ext_irq_in_zero_i,
  input wire logic ext_irq_in_one_i,
  output logic [1:0][CSD_CTL_W-1:0] ctl_o,
  output logic [1:0][CSD_AW-1:0] src_rd_o,
  output logic [1:0][CSD_AW-1:0] dst_rd_o,
  output logic [1:0][CSD_CW-1:0] cnt_o,
  output logic [1:0][CSD_CW-1:0] rld_o,
  output logic [1:0] irq_o,
  output logic bus_req_o,
  input wire logic bus_gnt_i,
  output logic acc_valid_o,
  output logic acc_write_o,
  output logic acc_byte_o,
  output logic [CSD_AW-1:0] acc_addr_o,
  output logic [CSD_DW-1:0] acc_wdata_o,
  input wire logic acc_ready_i,
  input wire logic [CSD_DW-1:0] acc_rdata_i
);
  typedef struct packed {
    logic [1:0][CSD_CTL_W-1:0] ctl;
    logic [1:0][CSD_AW-1:0] src;
    logic [1:0][CSD_AW-1:0] dst;
    logic [1:0][CSD_AW-1:0] fwd;
    logic [1:0][CSD_CW-1:0] rld;
    logic [1:0][CSD_CW-1:0] cnt;
    logic [1:0][CSD_AW-1:0] src_rd;
    logic [1:0][CSD_AW-1:0] dst_rd;
    logic [1:0] irq;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
    csd_state_t st;
    logic ch;
    logic beat;
    logic [CSD_DW-1:0] hold;
    logic bus_req;
    logic acc_valid;
    logic acc_write;
    logic acc_byte;
    logic [CSD_AW-1:0] acc_addr;
    logic [CSD_DW-1:0] acc_wdata;
  } csd_st_t;

  csd_st_t q;
  csd_st_t nxt;
  logic buf_push;
  logic buf_pop;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [CSD_DW-1:0] buf_out_data;

  function automatic logic csd_in_hole(input logic [CSD_AW-1:0] a);
    return (a >= CSD_HOLE_LO) && (a <= CSD_HOLE_HI);
  endfunction : csd_in_hole

  ////////////////////////////////////////////////////////////////////////////
  // Read data waits here so a slow destination loses no word
  csd_buf2 #(
    .WIDTH(CSD_DW),
    .DEPTH(CSD_BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .in_valid_i(buf_push),
    .in_ready_o(buf_in_ready),
    .in_data_i(q.hold),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for every register of the engine
  always_comb begin
    logic [1:0] evt;
    logic [1:0] edge_seen;
    logic [4:0] idx;
    logic cur;
    logic go;
    logic sfwd;
    logic dfwd;
    logic unit8;
    logic split_r;
    logic split_w;
    logic bdone;
    logic [CSD_AW-1:0] baddr_r;
    logic [CSD_AW-1:0] baddr_w;
    logic [CSD_DW-1:0] bdata;
    logic [CSD_DW-1:0] wbeat;
    nxt = q;
    evt = '0;
    edge_seen = '0;
    idx = '0;
    go = 1'b0;
    bdone = 1'b0;
    bdata = '0;
    buf_push = 1'b0;
    buf_pop = 1'b0;
    nxt.irq = '0;
    // Pins are asynchronous: two stages before the edge detector
    nxt.s1 = {ext_irq_in_one_i, ext_irq_in_zero_i};
    nxt.s2 = q.s1;
    nxt.prev = q.s2;

    // Request source per channel; each channel sees only its own pin
    for (int c = 0; c < CSD_CH_N; c++) begin
      edge_seen[c] = ext_both_edge_i[c] ? (q.prev[c] ^ q.s2[c])
                                         : (q.prev[c] & ~q.s2[c]); // R05
      idx = req_sel_i[c] - CSD_SEL_PER0;
      if (req_sel_i[c] == CSD_SEL_SW) begin
        evt[c] = sw_req_i[c]; // R06
      end else if (req_sel_i[c] == CSD_SEL_EXT) begin
        evt[c] = edge_seen[c];
      end else if (idx < CSD_PER_N) begin
        evt[c] = periph_irq_i[idx]; // R06
      end
    end

    // Working channel view
    cur = q.ch;
    sfwd = q.ctl[cur][CSD_B_SFWD];
    dfwd = q.ctl[cur][CSD_B_DFWD];
    unit8 = q.ctl[cur][CSD_B_UNIT];
    baddr_r = (sfwd ? q.fwd[cur] : q.src[cur]) + CSD_AW'(q.beat); // R02
    baddr_w = (dfwd ? q.fwd[cur] : q.dst[cur]) + CSD_AW'(q.beat);
    split_r = !unit8 && baddr_r[0] && !q.beat; // R19
    split_w = !unit8 && baddr_w[0] && !q.beat;
    if (q.beat) begin
      split_r = 1'b1;
      split_w = 1'b1;
    end
    wbeat = buf_out_data;
    if (split_w) begin
      wbeat = {CSD_BYTE_ZERO, q.beat ? buf_out_data[15:8] : buf_out_data[7:0]};
    end

    // Transfer sequencer: one read-write unit per bus tenure
    unique case (q.st)
      CSD_S_IDLE: begin
        if (q.ctl[0][CSD_B_REQ] && q.ctl[0][CSD_B_EN]) begin
          nxt.ch = 1'b0; // R01
          go = 1'b1;
        end else if (q.ctl[1][CSD_B_REQ] && q.ctl[1][CSD_B_EN]) begin
          nxt.ch = 1'b1;
          go = 1'b1; // R11
        end
        if (go) begin
          nxt.ctl[nxt.ch][CSD_B_REQ] = 1'b0; // R17
          nxt.bus_req = 1'b1; // R20
          nxt.st = CSD_S_REQ;
        end
      end
      CSD_S_REQ: begin
        if (bus_gnt_i) begin
          nxt.beat = 1'b0;
          nxt.st = CSD_S_RD;
        end
      end
      CSD_S_RD: begin
        // Hole addresses are skipped; such a read yields zero
        if (!q.acc_valid) begin
          if (csd_in_hole(baddr_r)) begin
            bdone = 1'b1; // R03
          end else begin
            nxt.acc_valid = 1'b1;
            nxt.acc_write = 1'b0;
            nxt.acc_addr = baddr_r;
            nxt.acc_byte = unit8 || split_r; // R04
          end
        end else if (acc_ready_i) begin
          bdone = 1'b1;
          bdata = acc_rdata_i;
          nxt.acc_valid = 1'b0;
        end
        if (bdone) begin
          if (split_r && !q.beat) begin
            nxt.hold[7:0] = bdata[7:0];
            nxt.beat = 1'b1;
          end else if (split_r) begin
            nxt.hold[15:8] = bdata[7:0];
            nxt.st = CSD_S_PUSH;
          end else begin
            nxt.hold = unit8 ? {CSD_BYTE_ZERO, bdata[7:0]} : bdata;
            nxt.st = CSD_S_PUSH;
          end
        end
      end
      CSD_S_PUSH: begin
        buf_push = 1'b1;
        if (buf_in_ready) begin
          nxt.beat = 1'b0;
          nxt.st = CSD_S_WR;
        end
      end
      CSD_S_WR: begin
        if (!q.acc_valid && buf_out_valid) begin
          if (csd_in_hole(baddr_w)) begin
            bdone = 1'b1; // R03
          end else begin
            nxt.acc_valid = 1'b1;
            nxt.acc_write = 1'b1;
            nxt.acc_addr = baddr_w;
            nxt.acc_byte = unit8 || split_w;
            nxt.acc_wdata = wbeat;
          end
        end else if (q.acc_valid && acc_ready_i) begin
          bdone = 1'b1;
          nxt.acc_valid = 1'b0;
          nxt.acc_write = 1'b0;
        end
        if (bdone && split_w && !q.beat) begin
          nxt.beat = 1'b1; // R19
        end else if (bdone) begin
          // Unit complete: give the bus back and advance the channel
          buf_pop = 1'b1;
          nxt.bus_req = 1'b0; // R20
          nxt.beat = 1'b0;
          nxt.st = CSD_S_IDLE;
          if (sfwd || dfwd) begin
            nxt.fwd[cur] = q.fwd[cur] + (unit8 ? CSD_STEP_B : CSD_STEP_W); // R21
          end
          nxt.cnt[cur] = q.cnt[cur] - CSD_CNT_ONE; // R21
          if (q.cnt[cur] == CSD_CNT_ZERO) begin
            nxt.irq[cur] = 1'b1; // R10
            if (q.ctl[cur][CSD_B_RPT]) begin
              nxt.cnt[cur] = q.rld[cur]; // R09
            end else begin
              nxt.ctl[cur][CSD_B_EN] = 1'b0; // R08
            end
          end
        end
      end
    endcase

    // Software writes come after the sequencer so software wins over it
    for (int c = 0; c < CSD_CH_N; c++) begin
      if (ctrl_we_i[c]) begin
        nxt.ctl[c] = CSD_CTL_RST | {2'h0,
          ctrl_wdata_i[CSD_B_DFWD] & ~ctrl_wdata_i[CSD_B_SFWD], // R07
          ctrl_wdata_i[CSD_B_SFWD], ctrl_wdata_i[CSD_B_EN],
          q.ctl[c][CSD_B_REQ] & ctrl_wdata_i[CSD_B_REQ], // R17
          ctrl_wdata_i[CSD_B_RPT], ctrl_wdata_i[CSD_B_UNIT]}; // R16
        if (ctrl_wdata_i[CSD_B_EN]) begin
          nxt.cnt[c] = q.rld[c]; // R12
          nxt.fwd[c] = ctrl_wdata_i[CSD_B_SFWD] ? q.src[c] : q.dst[c]; // R18
        end
      end
      if (src_we_i[c] && (q.ctl[c][CSD_B_SFWD] || !q.ctl[c][CSD_B_EN])) begin
        nxt.src[c] = ptr_wdata_i; // R13
      end
      if (dst_we_i[c] && (q.ctl[c][CSD_B_DFWD] || !q.ctl[c][CSD_B_EN])) begin
        nxt.dst[c] = ptr_wdata_i; // R13
      end
      if (rld_we_i[c]) begin
        nxt.rld[c] = rld_wdata_i;
      end
      // A request in the same cycle as any clear still lands
      if (evt[c]) begin
        nxt.ctl[c][CSD_B_REQ] = 1'b1; // R17
      end
      // Forward pointer reads back the live working pointer
      nxt.src_rd[c] = (nxt.ctl[c][CSD_B_EN] && nxt.ctl[c][CSD_B_SFWD]) ?
                      nxt.fwd[c] : nxt.src[c]; // R14
      nxt.dst_rd[c] = (nxt.ctl[c][CSD_B_EN] && nxt.ctl[c][CSD_B_DFWD]) ?
                      nxt.fwd[c] : nxt.dst[c]; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; peripheral interrupt lines are only sampled, never
  // acknowledged, so transfers leave interrupt state alone
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.st <= CSD_S_IDLE;
      q.s1 <= CSD_PIN_IDLE;
      q.s2 <= CSD_PIN_IDLE;
      q.prev <= CSD_PIN_IDLE; // R15
    end else if (ce_i) begin
      q <= nxt;
    end
  end

  // Every output straight from the state register
  assign ctl_o = q.ctl;
  assign src_rd_o = q.src_rd;
  assign dst_rd_o = q.dst_rd;
  assign cnt_o = q.cnt;
  assign rld_o = q.rld;
  assign irq_o = q.irq;
  assign bus_req_o = q.bus_req;
  assign acc_valid_o = q.acc_valid;
  assign acc_write_o = q.acc_write;
  assign acc_byte_o = q.acc_byte;
  assign acc_addr_o = q.acc_addr;
  assign acc_wdata_o = q.acc_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the engine's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_tie_ch_zero: assert property ( // R01
    (ce_i && q.st == CSD_S_IDLE && q.ctl[0][CSD_B_REQ] && q.ctl[0][CSD_B_EN])
    |=> (q.ch == 1'b0) && (q.st == CSD_S_REQ))
    else $error("channel zero lost a tie");

  a_hole_no_acc: assert property ( // R03
    acc_valid_o |-> !csd_in_hole(acc_addr_o))
    else $error("access into own register window");

  a_fwd_not_both: assert property ( // R07
    !(ctl_o[0][CSD_B_SFWD] && ctl_o[0][CSD_B_DFWD]) &&
    !(ctl_o[1][CSD_B_SFWD] && ctl_o[1][CSD_B_DFWD]))
    else $error("both directions forward");

  a_single_stop: assert property ( // R08
    (irq_o[0] && !ctl_o[0][CSD_B_RPT] && !$past(ctrl_we_i[0]))
    |-> !ctl_o[0][CSD_B_EN])
    else $error("single mode stayed enabled after underflow");

  a_repeat_reload: assert property ( // R09
    (irq_o[1] && ctl_o[1][CSD_B_RPT] && !$past(ctrl_we_i[1]))
    |-> ctl_o[1][CSD_B_EN] && cnt_o[1] == $past(rld_o[1]))
    else $error("repeat mode reload wrong");

  a_irq_underflow: assert property ( // R10
    $rose(irq_o[0]) |-> $past(cnt_o[0]) == CSD_CNT_ZERO)
    else $error("interrupt without underflow");

  a_start_enabled: assert property ( // R11
    (ce_i && q.st == CSD_S_IDLE && nxt.st == CSD_S_REQ)
    |-> q.ctl[nxt.ch][CSD_B_EN] ##1 bus_req_o)
    else $error("transfer started on disabled channel");

  a_enable_reload: assert property ( // R12
    (ce_i && ctrl_we_i[0] && ctrl_wdata_i[CSD_B_EN])
    |=> cnt_o[0] == $past(rld_o[0]))
    else $error("enable did not reload counter");

  a_fixed_wprot: assert property ( // R13
    (ce_i && src_we_i[1] && ctl_o[1][CSD_B_EN] && !ctl_o[1][CSD_B_SFWD])
    |=> q.src[1] == $past(q.src[1]))
    else $error("fixed pointer written while enabled");

  a_bus_tenure: assert property ( // R20
    (acc_valid_o |-> bus_req_o) and
    ($fell(bus_req_o) |-> $past(q.st) == CSD_S_WR))
    else $error("bus held outside one unit");
endmodule : csd_dma
`default_nettype wire

/* File: logic/README_unused.sv */
`timescale 1ns/1ns

/* File: testbench/csd_mem_model.sv */
// Behavioural bus arbiter and byte memory on the engine's far side.
// Assumes the engine's handshake as handed over and one shared clock.
`timescale 1ns/1ns
`default_nettype none
module csd_mem_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bus_req_i,
  output logic bus_gnt_o,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_byte_i,
  input wire logic [19:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic [15:0] acc_rdata_o
);
  logic [7:0] mem [int];
  int faults = 0;
  int seed = 52367;
  int a;
  // Unwritten bytes show an address pattern, so stale data is visible
  function automatic logic [7:0] rd_byte(int x);
    return mem.exists(x) ? mem[x] : (x[7:0] ^ 8'h5a);
  endfunction : rd_byte
  ////////////////////////////////////////////////////////////////////////////
  // Random grant and wait states; data lines toggle when not answering.
  // Reset lives in this process so each output has a single driver
  always @(posedge clk_i) begin
    a = int'(acc_addr_i);
    if (srst_i) begin
      bus_gnt_o <= 1'b0;
      acc_ready_o <= 1'b0;
      acc_rdata_o <= 16'h0000;
    end else begin
      bus_gnt_o <= bus_req_i && (bus_gnt_o || (($random(seed) & 1) == 0));
      if (acc_valid_i && !bus_gnt_o) faults++;
      if (acc_valid_i && a >= 32'h20 && a <= 32'h3f) faults++;
      if (acc_valid_i && !acc_byte_i && a[0]) faults++;
      if (acc_ready_o) begin
        acc_ready_o <= 1'b0;
        acc_rdata_o <= ~acc_rdata_o;
        if (acc_valid_i && acc_write_i) begin
          mem[a] = acc_wdata_i[7:0];
          if (!acc_byte_i) mem[a + 1] = acc_wdata_i[15:8];
        end
      end else if (acc_valid_i && ($random(seed) & 1)) begin
        acc_ready_o <= 1'b1;
        acc_rdata_o <= {rd_byte(a + 1), rd_byte(a)};
      end else begin
        acc_rdata_o <= ~acc_rdata_o;
      end
    end
  end
endmodule : csd_mem_model
`default_nettype wire

/* File: testbench/csd_dma_test.sv */
// Self-checking bench for the two-channel cycle-steal transfer engine.
// Assumes the memory model beside it answers bus and access requests.
`timescale 1ns/1ns
`default_nettype none
module csd_dma_test;
  import csd_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] ctrl_we_i = 2'h0, src_we_i = 2'h0, dst_we_i = 2'h0, rld_we_i = 2'h0;
  logic [7:0] ctrl_wdata_i = 8'h00;
  logic [19:0] ptr_wdata_i = 20'h00000, periph_irq_i = 20'h00000;
  logic [15:0] rld_wdata_i = 16'h0000;
  logic [1:0][4:0] req_sel_i = '0;
  logic [1:0] ext_both_edge_i = 2'h0, sw_req_i = 2'h0, irq_o;
  logic ext_zero = 1'b1, ext_one = 1'b1, ce = 1'b1;
  logic [1:0][7:0] ctl_o;
  logic [1:0][19:0] src_rd_o, dst_rd_o;
  logic [1:0][15:0] cnt_o, rld_o;
  logic bus_req_o, bus_gnt_i, acc_valid_o, acc_write_o, acc_byte_o, acc_ready_i;
  logic [19:0] acc_addr_o;
  logic [15:0] acc_wdata_o, acc_rdata_i;
  int bad_count = 0, checked = 0, seed = 52367, k;
  int irq_n [2] = '{0, 0}, irq_e [2] = '{0, 0};
  int e_src [2], e_dst [2], w_src [2], w_dst [2], e_cnt [2], e_rld [2];
  logic [7:0] e_ctl [2] = '{8'h00, 8'h00};
  logic [7:0] mir [int];
  int wq [$];

  always #5 clk_i = ~clk_i;
  // Count interrupt pulses, one per high cycle
  always @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) if (irq_o[c] === 1'b1) irq_n[c]++;
  end

  csd_dma i_csd_dma (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .ctrl_we_i(ctrl_we_i),
    .ctrl_wdata_i(ctrl_wdata_i), .src_we_i(src_we_i), .dst_we_i(dst_we_i),
    .ptr_wdata_i(ptr_wdata_i), .rld_we_i(rld_we_i), .rld_wdata_i(rld_wdata_i),
    .req_sel_i(req_sel_i), .ext_both_edge_i(ext_both_edge_i), .sw_req_i(sw_req_i),
    .periph_irq_i(periph_irq_i), .ext_irq_in_zero_i(ext_zero), .ext_irq_in_one_i(ext_one),
    .ctl_o(ctl_o), .src_rd_o(src_rd_o), .dst_rd_o(dst_rd_o), .cnt_o(cnt_o), .rld_o(rld_o),
    .irq_o(irq_o), .bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i), .acc_valid_o(acc_valid_o),
    .acc_write_o(acc_write_o), .acc_byte_o(acc_byte_o), .acc_addr_o(acc_addr_o),
    .acc_wdata_o(acc_wdata_o), .acc_ready_i(acc_ready_i), .acc_rdata_i(acc_rdata_i));
  csd_mem_model i_csd_mem_model (.clk_i(clk_i), .srst_i(srst_i), .bus_req_i(bus_req_o),
    .bus_gnt_o(bus_gnt_i), .acc_valid_i(acc_valid_o), .acc_write_i(acc_write_o),
    .acc_byte_i(acc_byte_o), .acc_addr_i(acc_addr_o), .acc_wdata_i(acc_wdata_o),
    .acc_ready_o(acc_ready_i), .acc_rdata_o(acc_rdata_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    bad_count += i_csd_mem_model.faults;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : cmp

  // One register write pulse, mirrored in the model
  task automatic wr(int kind, int ch, logic [19:0] v);
    @(posedge clk_i);
    ctrl_wdata_i <= v[7:0];
    ptr_wdata_i <= v;
    rld_wdata_i <= v[15:0];
    case (kind)
      0: ctrl_we_i[ch] <= 1'b1;
      1: src_we_i[ch] <= 1'b1;
      2: dst_we_i[ch] <= 1'b1;
      default: rld_we_i[ch] <= 1'b1;
    endcase
    @(posedge clk_i);
    {ctrl_we_i, src_we_i, dst_we_i, rld_we_i} <= 8'h00;
    if (kind == 1 && !(e_ctl[ch][3] && !e_ctl[ch][4])) w_src[ch] = v;
    if (kind == 2 && !(e_ctl[ch][3] && !e_ctl[ch][5])) w_dst[ch] = v;
    if (kind == 3) e_rld[ch] = v[15:0];
    if (kind == 0) begin
      e_ctl[ch] = {2'b00, v[5] & ~v[4], v[4:3], v[2] & e_ctl[ch][2], v[1:0]};
      if (v[3]) begin
        e_cnt[ch] = e_rld[ch];
        e_src[ch] = w_src[ch];
        e_dst[ch] = w_dst[ch];
      end
    end
  endtask : wr

  task automatic setup(int ch, logic [19:0] s, logic [19:0] d, logic [15:0] r, logic [7:0] c);
    wr(1, ch, s);
    wr(2, ch, d);
    wr(3, ch, {4'h0, r});
    wr(0, ch, {12'h000, c});
  endtask : setup

  task automatic fire(logic [1:0] m);
    @(posedge clk_i);
    sw_req_i <= m;
    @(posedge clk_i);
    sw_req_i <= 2'h0;
  endtask : fire

  // Wait out one bus tenure, bounded
  task automatic tenure();
    int t = 0;
    while (bus_req_o !== 1'b1 && t < 60) begin
      @(negedge clk_i);
      t++;
    end
    cmp("bus request", 1, bus_req_o);
    while (bus_req_o !== 1'b0 && t < 160) begin
      @(negedge clk_i);
      t++;
    end
    cmp("bus release", 0, bus_req_o);
    repeat (2) @(negedge clk_i);
  endtask : tenure

  function automatic logic [7:0] rb(int a);
    if (a >= 32'h20 && a <= 32'h3f) return 8'h00;
    return mir.exists(a) ? mir[a] : (a[7:0] ^ 8'h5a);
  endfunction : rb

  // Expected effect of one transfer unit
  task automatic unit_model(int ch);
    int n = e_ctl[ch][0] ? 1 : 2;
    for (int i = 0; i < n; i++) begin
      mir[e_dst[ch] + i] = rb(e_src[ch] + i);
      wq.push_back(e_dst[ch] + i);
    end
    if (e_ctl[ch][4]) e_src[ch] += n;
    if (e_ctl[ch][5]) e_dst[ch] += n;
    e_ctl[ch][2] = 1'b0;
    if (e_cnt[ch] != 0) begin
      e_cnt[ch]--;
    end else begin
      irq_e[ch]++;
      if (e_ctl[ch][1]) e_cnt[ch] = e_rld[ch];
      else e_ctl[ch][3] = 1'b0;
    end
  endtask : unit_model

  task automatic chk(int ch);
    @(negedge clk_i);
    cmp("control", e_ctl[ch], ctl_o[ch]);
    cmp("irq count", irq_e[ch], irq_n[ch]);
    cmp("reload", e_rld[ch], rld_o[ch]);
    if (e_ctl[ch][3]) begin
      cmp("counter", e_cnt[ch], cnt_o[ch]);
      cmp("source", e_src[ch], src_rd_o[ch]);
      cmp("dest", e_dst[ch], dst_rd_o[ch]);
    end
    while (wq.size() > 0) begin
      k = wq.pop_front();
      cmp("memory", mir[k], i_csd_mem_model.rd_byte(k));
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    chk(0);
    chk(1);
    cmp("idle bus", 0, bus_req_o);
    $display("test reset done");
    setup(0, 20'h01000, 20'h02000, 16'h0002, 8'hd9);
    repeat (3) begin
      fire(2'h1);
      tenure();
      unit_model(0);
      chk(0);
    end
    $display("test single byte done");
    setup(1, 20'h03001, 20'h04000, 16'h0001, 8'h2a);
    wr(1, 1, 20'h03100);
    repeat (3) begin
      fire(2'h2);
      tenure();
      unit_model(1);
      chk(1);
    end
    wr(0, 1, 20'h0002a);
    chk(1);
    $display("test repeat word done");
    wr(0, 0, 20'h00019);
    fire(2'h3);
    repeat (30) if (acc_valid_o !== 1'b1) @(negedge clk_i);
    cmp("first address", e_src[0], acc_addr_o);
    tenure();
    tenure();
    unit_model(0);
    unit_model(1);
    chk(0);
    chk(1);
    $display("test priority done");
    wr(0, 0, 20'h00000);
    fire(2'h1);
    repeat (10) @(negedge clk_i);
    cmp("no tenure", 0, bus_req_o);
    e_ctl[0][2] = 1'b1;
    chk(0);
    wr(0, 0, 20'h00000);
    chk(0);
    wr(0, 0, 20'h00030);
    chk(0);
    // Enable low: the trigger pulse must not be taken at all
    @(posedge clk_i);
    ce <= 1'b0;
    fire(2'h2);
    repeat (6) @(negedge clk_i);
    cmp("frozen request", 0, bus_req_o);
    chk(1);
    @(posedge clk_i);
    ce <= 1'b1;
    $display("test flags done");
    setup(0, 20'h00025, 20'h05000, 16'h0000, 8'h29);
    fire(2'h1);
    tenure();
    unit_model(0);
    chk(0);
    $display("test own window done");
    @(posedge clk_i);
    req_sel_i[1] <= CSD_SEL_EXT;
    ext_one <= 1'b0;
    tenure();
    unit_model(1);
    chk(1);
    @(posedge clk_i);
    ext_one <= 1'b1;
    repeat (12) @(negedge clk_i);
    cmp("rise ignored", 0, bus_req_o);
    @(posedge clk_i);
    ext_both_edge_i <= 2'h2;
    ext_one <= 1'b0;
    tenure();
    unit_model(1);
    chk(1);
    // A rise counts only in both-edge mode
    @(posedge clk_i);
    ext_one <= 1'b1;
    tenure();
    unit_model(1);
    chk(1);
    $display("test pin edges done");
    setup(0, 20'h10000 | 20'($random(seed) & 32'h0ffff), 20'h07000, 16'h0013, 8'h19);
    for (int c = 0; c < 20; c++) begin
      @(posedge clk_i);
      req_sel_i[0] <= CSD_SEL_PER0 + 5'(c);
      @(posedge clk_i);
      periph_irq_i <= 20'h00001 << c;
      @(posedge clk_i);
      periph_irq_i <= 20'h00000;
      tenure();
      unit_model(0);
      chk(0);
    end
    $display("test peripheral sources done");
    wr(0, 0, 20'h00019);
    @(posedge clk_i);
    req_sel_i[0] <= CSD_SEL_EXT;
    ext_zero <= 1'b0;
    tenure();
    unit_model(0);
    chk(0);
    $display("test pin zero done");
    conclude();
  end
endmodule : csd_dma_test
`default_nettype wire
